// ### verif/isp_master_model.sv
`default_nettype none
module isp_master_model
(
    // bus pins, data released means pulled up
    output logic scl,
    output logic sdaRel,
    input wire logic sdaLine
);
    timeunit 1ns;
    timeprecision 1ps;

    // quarter of the 125 ns bus clock
    localparam realtime Q = 31.25;

    initial
    begin
        scl = 1'b1;
        sdaRel = 1'b1;
    end

    // first quarter waits so data never moves at the clock fall
    task automatic start_cond();
        #Q sdaRel = 1'b1;
        #Q scl = 1'b1;
        #Q sdaRel = 1'b0;
        #Q scl = 1'b0;
    endtask

    // at least one clock pulse always precedes this
    task automatic stop_cond();
        #Q sdaRel = 1'b0;
        #Q scl = 1'b1;
        #Q sdaRel = 1'b1;
        #Q;
    endtask

    task automatic bit_io(input logic b, output logic got);
        #Q sdaRel = b;
        #Q scl = 1'b1;
        #Q got = sdaLine;
        #Q scl = 1'b0;
    endtask

    // ninth bit driven by the master when it receives
    task automatic byte_io(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
        for (int i = 7; i >= 0; i--)
            bit_io(tx[i], rx[i]);
        bit_io(ackIn, ackOut);
    endtask
endmodule
`default_nettype wire

// ### verif/test_isp_slave.sv
`default_nettype none
module test_isp_slave;
    timeunit 1ns;
    timeprecision 1ps;
    import isp_pkg::*;

    logic clock, arst_n, scl, sdaRel, sdaLine, sdaOut, sdaOe, regWrEn, wideSamples, rebootBusy, sampleMode;
    logic [6:0] slaveAddr;
    logic [1:0] bufSel;
    isp_byte_t regAddr, regWrData, regRdData;
    isp_index_t bufIndex, bufOldest;
    isp_sample_t bufData;
    int err_total, check_count;
    logic [15:0] wq[$];

    function automatic isp_byte_t rd_val(isp_byte_t a);
        return a ^ 8'hA5;
    endfunction
    function automatic isp_sample_t smp(logic [1:0] s, isp_index_t i);
        return {s, i, i[1:0] ^ s};
    endfunction

    // open drain wire, pulled up when nobody pulls low
    assign sdaLine = sdaRel & (sdaOe ? sdaOut : 1'b1);
    assign regRdData = rd_val(regAddr);
    assign bufData = smp(bufSel, bufIndex);

    isp_master_model mst_u (.scl(scl), .sdaRel(sdaRel), .sdaLine(sdaLine));
    isp_slave dut_u (.clock(clock), .arst_n(arst_n), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
        .sdaOe(sdaOe), .slaveAddr(slaveAddr), .wideSamples(wideSamples), .rebootBusy(rebootBusy),
        .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdData(regRdData),
        .bufSel(bufSel), .bufIndex(bufIndex), .bufOldest(bufOldest), .bufData(bufData),
        .sampleMode(sampleMode));

    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    // falling edge avoids racing the pointer update
    always @(negedge clock)
        if (regWrEn === 1'b1)
            wq.push_back({regAddr, regWrData});

    task automatic close_out();
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk_byte(input isp_byte_t got, input isp_byte_t exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("CHECK FAILED %0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    task automatic xb(input isp_byte_t tx, input logic ackIn, input logic expAck, output isp_byte_t rx);
        logic a;
        mst_u.byte_io(tx, ackIn, rx, a);
        chk_bit(a, expAck, "ninth bit");
    endtask

    task automatic addr_go(input logic rd);
        isp_byte_t r;
        mst_u.start_cond();
        xb({slaveAddr, rd}, 1'b1, 1'b0, r);
    endtask

    task automatic ptr_load(input isp_byte_t p, input logic expAck);
        isp_byte_t r;
        addr_go(1'b0);
        xb(p, 1'b1, expAck, r);
        mst_u.stop_cond();
    endtask

    task automatic rd_buf(input logic [1:0] k, input logic w);
        isp_byte_t r;
        isp_sample_t s;
        int n;
        n = w ? 100 : 51;
        ptr_load(8'h46 + k, 1'b0);
        chk_bit(sampleMode, 1'b1, "mode on");
        addr_go(1'b1);
        for (int i = 0; i < n; i++)
        begin
            s = smp(k, 6'((bufOldest + 1 + (w ? i / 2 : i)) % 50));
            xb(8'hFF, i == n - 1, i == n - 1, r);
            chk_byte(r, (w && i % 2 == 1) ? {6'h00, s[1:0]} : s[9:2], "sample");
        end
        chk_byte(regAddr, 8'h46 + k, "base kept");
        mst_u.stop_cond();
        chk_bit(sampleMode, 1'b0, "mode off");
    endtask

    initial
    begin
        #800_000;
        err_total++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        close_out();
    end

    initial
    begin
        isp_byte_t r, d;
        err_total = 0;
        check_count = 0;
        arst_n = 1'b0;
        wideSamples = 1'b0;
        rebootBusy = 1'b0;
        bufOldest = 6'h00;
        void'($urandom(65137));
        slaveAddr = 7'($urandom_range(8'h08, 8'h77));
        repeat (8) @(posedge clock);
        #1 arst_n = 1'b1;
        chk_bit(sdaOe, 1'b0, "reset oe");
        chk_bit(regWrEn, 1'b0, "reset wr");
        chk_bit(sampleMode, 1'b0, "reset mode");
        chk_byte(regAddr, 8'h00, "reset ptr");
        repeat (10) @(posedge clock);
        #1 mst_u.start_cond();
        xb({slaveAddr ^ 7'h01, 1'b0}, 1'b1, 1'b1, r);
        mst_u.stop_cond();
        @(posedge clock);
        #1 rebootBusy = 1'b1;
        mst_u.start_cond();
        xb({slaveAddr, 1'b1}, 1'b1, 1'b1, r);
        mst_u.stop_cond();
        chk_bit(sdaOe, 1'b0, "released after refusal");
        @(posedge clock);
        #1 rebootBusy = 1'b0;
        // a pause before retrying a refused transfer
        repeat (200) @(posedge clock);
        #1 ptr_load(8'h10, 1'b0);
        chk_byte(regAddr, 8'h10, "ptr after stop");
        for (int i = 0; i < 4; i++)
        begin
            ptr_load(i == 0 ? 8'h4A : 8'($urandom_range(8'h4A, 8'hFF)), 1'b1);
            chk_byte(regAddr, 8'h10, "ptr kept");
        end
        addr_go(1'b0);
        xb(8'h44, 1'b1, 1'b0, r);
        for (int i = 0; i < 3; i++)
        begin
            d = 8'($urandom);
            xb(d, 1'b1, 1'b0, r);
            chk_byte(wq[i][7:0], d, "wr data");
            chk_byte(wq[i][15:8], i == 0 ? 8'h44 : (i == 1 ? 8'h45 : 8'h00), "wr addr");
        end
        mst_u.stop_cond();
        chk_byte(regAddr, 8'h01, "ptr wrapped");
        addr_go(1'b0);
        xb(8'h47, 1'b1, 1'b0, r);
        xb(8'h5C, 1'b1, 1'b1, r);
        mst_u.stop_cond();
        chk_byte(8'(wq.size()), 8'h03, "no store");
        addr_go(1'b0);
        xb(8'h45, 1'b1, 1'b0, r);
        addr_go(1'b1);
        for (int i = 0; i < 3; i++)
        begin
            xb(8'hFF, i == 2, i == 2, r);
            chk_byte(r, rd_val(i == 0 ? 8'h45 : 8'(i - 1)), "reg read");
        end
        mst_u.stop_cond();
        addr_go(1'b0);
        for (int i = 0; i < 3; i++)
            mst_u.bit_io(1'b0, r[i]);
        mst_u.stop_cond();
        ptr_load(8'h21, 1'b0);
        chk_byte(regAddr, 8'h21, "after early stop");
        for (int k = 0; k < 5; k++)
        begin
            @(posedge clock);
            #1 bufOldest = k == 0 ? 6'h31 : 6'($urandom_range(49));
            wideSamples = k == 4;
            rd_buf(2'(k), k == 4);
        end
        close_out();
    end
endmodule
`default_nettype wire

// ### verilog/isp_line_if.sv
`default_nettype none
interface isp_line_if;
    logic sclLvl;
    logic sdaLvl;
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;

    modport src (output sclLvl, output sdaLvl, output sclRise, output sclFall, output startSeen, output stopSeen);
    modport dst (input sclLvl, input sdaLvl, input sclRise, input sclFall, input startSeen, input stopSeen);
endinterface
`default_nettype wire

// ### verilog/isp_line_sync.sv
`default_nettype none
module isp_line_sync
(
    // system
    input wire logic clock,
    input wire logic arst_n,
    // raw bus lines, index 0 clock line, 1 data line
    input wire logic sclIn,
    input wire logic sdaIn,
    // filtered levels and events
    isp_line_if.src lines
);
    logic [1:0] rawLine;
    logic [1:0] lvl;
    logic [1:0] prev;

    assign rawLine = {sdaIn, sclIn};

    genvar i;
    generate
        for (i = 0; i < 2; i++)
        begin : g_line
            logic s1_r;
            logic s2_r;
            logic s3_r;
            logic lvl_r;
            logic prev_r;
            // idle-high bus, so every stage resets to one
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    s1_r <= 1'b1;
                    s2_r <= 1'b1;
                    s3_r <= 1'b1;
                end
                else
                begin
                    s1_r <= rawLine[i];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                end
            end
            // a level change counts only once two late stages agree
            always_ff @(posedge clock or negedge arst_n)
            begin
                if (!arst_n)
                begin
                    lvl_r <= 1'b1;
                    prev_r <= 1'b1;
                end
                else
                begin
                    lvl_r <= (s2_r == s3_r) ? s2_r : lvl_r;
                    prev_r <= lvl_r;
                end
            end
            assign lvl[i] = lvl_r;
            assign prev[i] = prev_r;
        end
    endgenerate

    assign lines.sclLvl = lvl[0];
    assign lines.sdaLvl = lvl[1];
    assign lines.sclRise = lvl[0] && !prev[0];
    assign lines.sclFall = !lvl[0] && prev[0];
    // data moving while the clock line stays high frames a transfer
    assign lines.startSeen = lvl[0] && prev[0] && !lvl[1] && prev[1];
    assign lines.stopSeen = lvl[0] && prev[0] && lvl[1] && !prev[1];
endmodule
`default_nettype wire

// ### verilog/isp_params.svh
`ifndef ISP_PARAMS_SVH
`define ISP_PARAMS_SVH

// pointer map
`define ISP_PTR_CFG_MAX 8'h45
`define ISP_PTR_BUF_FIRST 8'h46
`define ISP_PTR_BUF_LAST 8'h49
`define ISP_PTR_RESET 8'h00

// byte framing
`define ISP_BITS_PER_BYTE 4'h8
`define ISP_LAST_BIT 4'h7

// sample buffer geometry
`define ISP_BUF_LAST_IDX 6'h31
`define ISP_BUF_FIRST_IDX 6'h00

`endif

// ### verilog/isp_pkg.sv
`default_nettype none
package isp_pkg;

    typedef logic [7:0] isp_byte_t;
    typedef logic [5:0] isp_index_t;
    typedef logic [9:0] isp_sample_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_RX,
        ST_RACK,
        ST_TX,
        ST_TACK,
        ST_WAIT
    } isp_state_t;

    typedef enum logic [1:0] {
        RB_ADDR,
        RB_PTR,
        RB_DATA
    } isp_role_t;

endpackage
`default_nettype wire

// ### verilog/isp_sample_order.sv
`include "isp_params.svh"
`default_nettype none
module isp_sample_order
(
    // system
    input wire logic clock,
    input wire logic arst_n,
    // control
    input wire logic restart,
    input wire logic advance,
    input wire isp_pkg::isp_index_t oldest,
    // read position
    output isp_pkg::isp_index_t index
);
    import isp_pkg::*;

    isp_index_t index_r;
    isp_index_t index_nxt;
    isp_index_t afterOldest;
    isp_index_t afterIndex;

    // ring of fifty: step past the oldest, then walk forward and wrap
    assign afterOldest = (oldest == `ISP_BUF_LAST_IDX) ? `ISP_BUF_FIRST_IDX : oldest + 6'h01;
    assign afterIndex = (index_r == `ISP_BUF_LAST_IDX) ? `ISP_BUF_FIRST_IDX : index_r + 6'h01;
    assign index_nxt = restart ? afterOldest : (advance ? afterIndex : index_r);
    assign index = index_r;

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
            index_r <= `ISP_BUF_FIRST_IDX;
        else
            index_r <= index_nxt;
    end
endmodule
`default_nettype wire

// ### verilog/isp_slave.sv
// Operation
// - acknowledge own address and accepted bytes by holding data low in ninth clock
// - release data in ninth clock of a sent byte and sample master acknowledge
// - refuse own address while reboot is busy, refuse illegal pointer values
// - address plus one written byte loads the register pointer, both acknowledged
// - refuse the pointer byte when its value is not permitted
// - stop leaves the pointer alone; only load or increment change it
// - write data bytes to registers 0x00-0x45 are acknowledged, stored, then pointer increments
// - store data only when the addressed register is 0x00 to 0x45
// - pointer wraps to zero past the highest register, reads and writes
// - read sends eight bits, increments pointer, continues on master acknowledge
// - pointers 0x00-0x45 registers, 0x46-0x49 buffer bases, others refused
// - loading a buffer base enters sample readout mode
// - sample readout mode suppresses pointer increment
// - first master not-acknowledge ends sample readout mode
// - narrow format delivers one sample per byte then advances
// - wide format sends upper eight bits then low two bits right-aligned
// - readout starts next-to-oldest, runs to newest, oldest last
// - slave only; master drives the clock and starts transfers
// - stop is detected anywhere in a transfer
// - repeated start accepted between transfers and for direction change
`include "isp_params.svh"
`default_nettype none
module isp_slave
(
    // system
    input wire logic clock,
    input wire logic arst_n,
    // two-wire bus, data line is open drain
    input wire logic sclIn,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // static configuration
    input wire logic [6:0] slaveAddr,
    input wire logic wideSamples,
    input wire logic rebootBusy,
    // register bank
    output isp_pkg::isp_byte_t regAddr,
    output isp_pkg::isp_byte_t regWrData,
    output logic regWrEn,
    input wire isp_pkg::isp_byte_t regRdData,
    // sample buffers
    output logic [1:0] bufSel,
    output isp_pkg::isp_index_t bufIndex,
    input wire isp_pkg::isp_index_t bufOldest,
    input wire isp_pkg::isp_sample_t bufData,
    // status
    output logic sampleMode
);
    import isp_pkg::*;

    isp_line_if lines();

    isp_line_sync u_sync
    (
        .clock(clock),
        .arst_n(arst_n),
        .sclIn(sclIn),
        .sdaIn(sdaIn),
        .lines(lines.src)
    );

    isp_state_t state_r;
    isp_state_t state_nxt;
    isp_role_t role_r;
    isp_role_t role_nxt;
    logic [3:0] bitCnt_r;
    logic [3:0] bitCnt_nxt;
    isp_byte_t rxByte_r;
    isp_byte_t rxByte_nxt;
    isp_byte_t txByte_r;
    isp_byte_t txByte_nxt;
    isp_byte_t ptr_r;
    isp_byte_t ptr_nxt;
    logic rdDir_r;
    logic rdDir_nxt;
    logic ackOn_r;
    logic ackOn_nxt;
    logic sdaOe_r;
    logic sdaOe_nxt;
    logic mAck_r;
    logic mAck_nxt;
    logic sampleMode_r;
    logic sampleMode_nxt;
    logic half_r;
    logic half_nxt;

    // decode of the byte just received
    logic evFree;
    logic addrHit;
    logic ptrLegal;
    logic isBufBase;
    logic ackOk;
    logic byteIn;
    logic loadPtr;
    logic wrFire;
    logic byteOut;
    logic incPtr;
    logic sampleStep;
    logic masterNack;
    isp_byte_t ptrWrapped;
    isp_byte_t bufOffset;
    isp_byte_t txSource;

    assign evFree = !lines.startSeen && !lines.stopSeen;
    assign addrHit = (rxByte_r[7:1] == slaveAddr);
    assign ptrLegal = (rxByte_r <= `ISP_PTR_BUF_LAST);
    assign isBufBase = (rxByte_r >= `ISP_PTR_BUF_FIRST) && ptrLegal;

    // data into a buffer base is not a register write, so it is refused
    assign ackOk = (role_r == RB_ADDR) ? (addrHit && !rebootBusy) :
        (role_r == RB_PTR) ? ptrLegal :
        (ptr_r <= `ISP_PTR_CFG_MAX);

    assign byteIn = (state_r == ST_RX) && lines.sclFall && (bitCnt_r == `ISP_BITS_PER_BYTE) && evFree;
    assign loadPtr = byteIn && (role_r == RB_PTR) && ackOk;
    assign wrFire = byteIn && (role_r == RB_DATA) && ackOk;
    assign byteOut = (state_r == ST_TX) && lines.sclFall && (bitCnt_r == `ISP_LAST_BIT) && evFree;
    assign incPtr = wrFire || (byteOut && !sampleMode_r);
    assign sampleStep = byteOut && sampleMode_r && (!wideSamples || half_r);
    assign masterNack = (state_r == ST_TACK) && lines.sclRise && lines.sdaLvl && evFree;

    assign ptrWrapped = (ptr_r == `ISP_PTR_CFG_MAX) ? `ISP_PTR_RESET : ptr_r + 8'h01;
    assign bufOffset = ptr_r - `ISP_PTR_BUF_FIRST;
    assign txSource = !sampleMode_r ? regRdData :
        (wideSamples && half_r) ? {6'h00, bufData[1:0]} :
        bufData[9:2];

    // pointer and readout mode survive stop conditions
    assign ptr_nxt = loadPtr ? rxByte_r : (incPtr ? ptrWrapped : ptr_r);
    assign sampleMode_nxt = loadPtr ? isBufBase : (masterNack ? 1'b0 : sampleMode_r);
    assign half_nxt = (loadPtr || masterNack) ? 1'b0 :
        (byteOut && sampleMode_r && wideSamples) ? !half_r : half_r;

    isp_sample_order u_order
    (
        .clock(clock),
        .arst_n(arst_n),
        .restart(loadPtr && isBufBase),
        .advance(sampleStep),
        .oldest(bufOldest),
        .index(bufIndex)
    );

    // bit engine: shift on rising clock, drive on falling clock
    always_comb
    begin
        state_nxt = state_r;
        role_nxt = role_r;
        bitCnt_nxt = bitCnt_r;
        rxByte_nxt = rxByte_r;
        txByte_nxt = txByte_r;
        rdDir_nxt = rdDir_r;
        ackOn_nxt = ackOn_r;
        sdaOe_nxt = sdaOe_r;
        mAck_nxt = mAck_r;
        if (lines.stopSeen)
        begin
            state_nxt = ST_IDLE;
            sdaOe_nxt = 1'b0;
        end
        else if (lines.startSeen)
        begin
            state_nxt = ST_RX;
            role_nxt = RB_ADDR;
            bitCnt_nxt = 4'h0;
            sdaOe_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                ST_RX:
                begin
                    if (lines.sclRise && (bitCnt_r != `ISP_BITS_PER_BYTE))
                    begin
                        rxByte_nxt = {rxByte_r[6:0], lines.sdaLvl};
                        bitCnt_nxt = bitCnt_r + 4'h1;
                    end
                    else if (byteIn)
                    begin
                        state_nxt = ST_RACK;
                        ackOn_nxt = ackOk;
                        sdaOe_nxt = ackOk;
                        if (role_r == RB_ADDR)
                            rdDir_nxt = rxByte_r[0];
                    end
                end
                ST_RACK:
                begin
                    if (lines.sclFall)
                    begin
                        sdaOe_nxt = 1'b0;
                        bitCnt_nxt = 4'h0;
                        if (!ackOn_r)
                            state_nxt = ST_WAIT;
                        else if ((role_r == RB_ADDR) && rdDir_r)
                        begin
                            state_nxt = ST_TX;
                            txByte_nxt = txSource;
                            sdaOe_nxt = !txSource[7];
                        end
                        else
                        begin
                            state_nxt = ST_RX;
                            role_nxt = (role_r == RB_ADDR) ? RB_PTR : RB_DATA;
                        end
                    end
                end
                ST_TX:
                begin
                    if (byteOut)
                    begin
                        state_nxt = ST_TACK;
                        sdaOe_nxt = 1'b0;
                    end
                    else if (lines.sclFall)
                    begin
                        bitCnt_nxt = bitCnt_r + 4'h1;
                        txByte_nxt = {txByte_r[6:0], 1'b0};
                        sdaOe_nxt = !txByte_r[6];
                    end
                end
                ST_TACK:
                begin
                    if (lines.sclRise)
                        mAck_nxt = !lines.sdaLvl;
                    else if (lines.sclFall)
                    begin
                        bitCnt_nxt = 4'h0;
                        if (mAck_r)
                        begin
                            state_nxt = ST_TX;
                            txByte_nxt = txSource;
                            sdaOe_nxt = !txSource[7];
                        end
                        else
                            state_nxt = ST_WAIT;
                    end
                end
                default:
                begin
                    state_nxt = state_r;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= ST_IDLE;
            role_r <= RB_ADDR;
            bitCnt_r <= 4'h0;
            rxByte_r <= 8'h00;
            txByte_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            role_r <= role_nxt;
            bitCnt_r <= bitCnt_nxt;
            rxByte_r <= rxByte_nxt;
            txByte_r <= txByte_nxt;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdDir_r <= 1'b0;
            ackOn_r <= 1'b0;
            sdaOe_r <= 1'b0;
            mAck_r <= 1'b0;
        end
        else
        begin
            rdDir_r <= rdDir_nxt;
            ackOn_r <= ackOn_nxt;
            sdaOe_r <= sdaOe_nxt;
            mAck_r <= mAck_nxt;
        end
    end

    always_ff @(posedge clock or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ptr_r <= `ISP_PTR_RESET;
            sampleMode_r <= 1'b0;
            half_r <= 1'b0;
        end
        else
        begin
            ptr_r <= ptr_nxt;
            sampleMode_r <= sampleMode_nxt;
            half_r <= half_nxt;
        end
    end

    // open drain: only ever pull low, never drive high
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_r;
    assign regAddr = ptr_r;
    assign regWrData = rxByte_r;
    assign regWrEn = wrFire;
    assign bufSel = bufOffset[1:0];
    assign sampleMode = sampleMode_r;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    a_ack_holds_low: assert property ((state_r == ST_RACK) && ackOn_r |-> sdaOe && !sdaOut)
        else $error("acknowledge not driven in ninth clock");
    a_tx_ack_free: assert property ((state_r == ST_TACK) |-> !sdaOe)
        else $error("data line held during master acknowledge");
    a_reboot_nack: assert property (byteIn && (role_r == RB_ADDR) && rebootBusy
        |=> !sdaOe && !ackOn_r && (state_r == ST_RACK))
        else $error("address acknowledged during reboot");
    a_bad_ptr_nack: assert property (byteIn && (role_r == RB_PTR) && (rxByte_r > `ISP_PTR_BUF_LAST)
        |=> !sdaOe && (state_r == ST_RACK))
        else $error("illegal pointer acknowledged");
    a_ptr_load: assert property (loadPtr |=> (ptr_r == $past(rxByte_r)))
        else $error("pointer not loaded from pointer byte");
    a_stop_keeps_ptr: assert property (lines.stopSeen |=> $stable(ptr_r))
        else $error("stop changed the pointer");
    a_ptr_wraps: assert property (incPtr && (ptr_r == `ISP_PTR_CFG_MAX) |=> (ptr_r == `ISP_PTR_RESET))
        else $error("pointer did not wrap to zero");
    a_store_valid: assert property (regWrEn |-> (regAddr <= `ISP_PTR_CFG_MAX) && (state_r == ST_RX))
        else $error("write stored at invalid register");
    a_buf_mode_entry: assert property (loadPtr && isBufBase |=> sampleMode &&
        (bufIndex == (($past(bufOldest) == `ISP_BUF_LAST_IDX) ? `ISP_BUF_FIRST_IDX : $past(bufOldest) + 6'h01)))
        else $error("buffer base did not enter readout mode");
    a_buf_no_inc: assert property (sampleMode_r && !loadPtr |=> $stable(ptr_r))
        else $error("pointer moved during sample readout");
    a_nack_ends_buf: assert property (masterNack |=> !sampleMode && !half_r)
        else $error("master nack did not end readout mode");
    a_wide_low_byte: assert property (byteOut && sampleMode_r && wideSamples && !half_r
        |=> half_r && $stable(bufIndex))
        else $error("wide sample advanced after upper byte");

    c_ptr_load: cover property (loadPtr ##[1:400] lines.stopSeen);
    c_reg_write: cover property (wrFire);
    c_reg_read: cover property (byteOut && !sampleMode_r ##[1:40] (state_r == ST_TX));
    c_buf_nack: cover property (sampleStep ##[1:200] masterNack);
endmodule
`default_nettype wire
